// file: rtl/fsr_defines.svh
// Constants for the flash status and busy report block: opcodes,
// field positions and reset values.
// Assumes inclusion by bare name from the design file and the bench files.
`ifndef FSR_DEFINES_SVH
`define FSR_DEFINES_SVH

// Serial opcodes seen by the status logic
`define FSR_OP_RD_STAT1   8'h05
`define FSR_OP_RD_STAT2   8'h35
`define FSR_OP_ASI        8'h25
`define FSR_OP_WREN       8'h06
`define FSR_OP_WRDI       8'h04
`define FSR_OP_WRSR1      8'h01
`define FSR_OP_WRSR2      8'h31
`define FSR_OP_RESET      8'hf0
`define FSR_OP_PROG       8'h02
`define FSR_OP_ERASE_4K   8'h20
`define FSR_OP_ERASE_64K  8'hd8
`define FSR_OP_CHIP_ERASE 8'h60
`define FSR_OP_PROTECT    8'h36
`define FSR_OP_UNPROTECT  8'h39
`define FSR_OP_SEQ_PROG   8'had

// Field positions
`define FSR_RESET_COMMAND_ENABLE_BIT      4

// Software protection field codes
`define FSR_SWP_NONE      2'h0
`define FSR_SWP_SOME      2'h1
`define FSR_SWP_ALL       2'h3

// Reset values
`define FSR_WEL_RST       1'h0
`define FSR_EPE_RST       1'h0
`define FSR_RESET_COMMAND_ENABLE_RST      1'h0

`endif

// file: rtl/fsr_pkg.sv
// Types for the flash status and busy report block.
// Assumes nothing beyond the defines header.
`default_nettype none
package fsr_pkg;

   // One-hot serial command states
   typedef enum logic [6:0]
   {
      fsr_st_idle = 7'h01,
      fsr_st_opc  = 7'h02,
      fsr_st_rd1  = 7'h04,
      fsr_st_rd2  = 7'h08,
      fsr_st_asi  = 7'h10,
      fsr_st_wr2  = 7'h20,
      fsr_st_tail = 7'h40
   } fsr_state_t;

   // Whole state of the status block
   typedef struct packed
   {
      fsr_state_t st;        // Command state
      logic       sck_q;     // Previous serial clock
      logic       cs_q;      // Previous chip select, active low
      logic [2:0] bits;      // Bit within byte
      logic [1:0] bytes;     // Full bytes seen, saturating
      logic [7:0] opcode;    // Opcode shifter
      logic [7:0] data;      // Data byte shifter
      logic [7:0] shreg;     // Outgoing status byte
      logic       write_enable_latch;       // Write enable latch
      logic       program_erase_error;       // Program/erase error
      logic       reset_command_enable;      // Reset command enable
      logic       so;        // Serial output value
      logic       so_oe;     // Serial output drive
      logic       grant;     // Command grant pulse
      logic [7:0] grant_op;  // Granted opcode
      logic       srst;      // Soft reset pulse
   } fsr_regs_t;

endpackage
`default_nettype wire

// file: rtl/fsr_status.sv
// Status reporting logic of a serial flash: status bytes, write enable
// latch, error flag, reset enable and live busy signalling.
// Assumes SPI pins already synchronous to clock and the serial clock at
// most a quarter of clock; the array engine reports through pulses.
`timescale 1ns/100ps
`default_nettype none
`include "fsr_defines.svh"

// Function
// (R01) Failed byte sets the error flag
// (R02) Aborted operations leave error flag alone
// (R03) Error flag refreshed after every operation
// (R04) Write-protect pin level readable in status
// (R05) Two-bit field reports sector protection
// (R06) Clear latch rejects write-type commands
// (R07) Latch clears at power-up and reset
// (R08) Latch clears when write operations finish/stop
// (R09) Latch clears at sequential programming end
// (R10) Incomplete opcode keeps a set latch
// (R11) Full write-type opcode clears latch on stop
// (R12) Host polls status until busy falls
// (R13) Busy flag at bit 0 both bytes
// (R14) Reset command needs reset-enable bit set
// (R15) Reset-enable powers up zero, holds value
// (R16) Reset command leaves reset-enable unchanged
// (R17) Reserved second-byte bits read zero
// (R18) Second-byte write changes only bit 4
// (R19) Host sends opcode 25h under chip select
// (R20) Mode 3 host adds one dummy bit
// (R21) Live busy driven while chip select held
// (R22) Live busy output never rises
// (R23) Chip select release tri-states output
// (R24) Protection codes 00, 01, 11
// (R25) Error flag one on error, else zero
module fsr_status
(
   input  wire logic       clock,                   // 100 MHz system clock
   input  wire logic       nrst,                    // Async reset, active low
   input  wire logic       cs_n,                    // Chip select, active low
   input  wire logic       sck,                     // Serial clock
   input  wire logic       si,                      // Serial input
   input  wire logic       busy,                    // Engine busy level
   input  wire logic       op_done,                 // Operation finished pulse
   input  wire logic       op_fail,                 // Byte failed, with op_done
   input  wire logic       op_abort,                // Operation stopped pulse
   input  wire logic       seq_end,                 // Sequential end reached
   input  wire logic       hold_stop,               // Hold condition stopped
   input  wire logic       protect_pin_level,       // Protect pin, 1 released
   input  wire logic       sectors_some,            // Some sectors protected
   input  wire logic       sectors_all,             // All sectors protected
   input  wire logic       protection_regs_lock,    // Lock bit from outside
   input  wire logic       sequential_program_flag, // Sequential mode flag
   output logic            so,                      // Serial output value
   output logic            so_oe,                   // Serial output enable
   output logic            exec_grant,              // Command grant pulse
   output logic [7:0]      exec_opcode,             // Granted opcode
   output logic            soft_reset               // Soft reset pulse
);

   fsr_pkg::fsr_regs_t r_reg;   // Registered state
   fsr_pkg::fsr_regs_t r_next;  // Next state

   // Protection field from the two summary inputs
   function automatic logic [1:0] swp_code(input logic some, input logic all);
      if (all)
         swp_code = `FSR_SWP_ALL;  // R24
      else if (some)
         swp_code = `FSR_SWP_SOME; // R24
      else
         swp_code = `FSR_SWP_NONE; // R24
   endfunction

   // Opcodes that need the write enable latch
   function automatic logic is_write_op(input logic [7:0] op);
      is_write_op = (op == `FSR_OP_PROG) || (op == `FSR_OP_ERASE_4K) ||
                    (op == `FSR_OP_ERASE_64K) || (op == `FSR_OP_CHIP_ERASE) ||
                    (op == `FSR_OP_PROTECT) || (op == `FSR_OP_UNPROTECT) ||
                    (op == `FSR_OP_WRSR1) || (op == `FSR_OP_SEQ_PROG);
   endfunction

   // Edge and frame decodes of the serial pins
   logic sck_rise;   // Sample edge
   logic sck_fall;   // Shift edge
   logic cs_begin;   // Frame start
   logic cs_end;     // Frame end
   logic [7:0] opc_shift;  // Opcode including current bit
   logic [7:0] stat1;      // First status byte
   logic [7:0] stat2;      // Second status byte
   logic [7:0] stat_sel;   // Byte chosen for the read in progress
   logic       wel_event;  // Hardware clear of the latch

   assign sck_rise  = sck & ~r_reg.sck_q & ~cs_n;
   assign sck_fall  = ~sck & r_reg.sck_q & ~cs_n;
   assign cs_begin  = ~cs_n & r_reg.cs_q;
   assign cs_end    = cs_n & ~r_reg.cs_q;
   assign opc_shift = {r_reg.opcode[6:0], si};
   // Busy at bit 0 of both bytes; reserved second-byte bits zero
   assign stat1 = {protection_regs_lock, sequential_program_flag, r_reg.program_erase_error,
                   protect_pin_level, swp_code(sectors_some, sectors_all),
                   r_reg.write_enable_latch, busy}; // R04 R05 R13
   assign stat2 = {3'h0, r_reg.reset_command_enable, 3'h0, busy}; // R13 R17
   assign stat_sel  = (r_reg.st == fsr_pkg::fsr_st_rd2) ? stat2 : stat1;
   assign wel_event = op_done | op_abort | seq_end | hold_stop;

   // Next-state logic for the whole block
   always_comb
   begin
      r_next       = r_reg;
      r_next.sck_q = sck;
      r_next.cs_q  = cs_n;
      r_next.grant = 1'b0;
      r_next.srst  = 1'b0;

      // Engine events: finish refreshes the error flag
      if (op_done)
      begin
         r_next.program_erase_error = op_fail; // R01 R03 R25
      end
      // Aborts leave the error flag as it was
      if (wel_event)
      begin
         r_next.write_enable_latch = 1'b0; // R02 R08 R09
      end

      if (cs_n)
      begin
         // Released: output off at once, any byte position
         r_next.st    = fsr_pkg::fsr_st_idle; // R23
         r_next.so    = 1'b0;
         r_next.so_oe = 1'b0; // R23
      end
      else if (cs_begin)
      begin
         // New frame
         r_next.st    = fsr_pkg::fsr_st_opc;
         r_next.bits  = 3'h0;
         r_next.bytes = 2'h0;
      end
      else
      begin
         case (r_reg.st)
            fsr_pkg::fsr_st_opc:
            begin
               // Collect the opcode on sample edges
               if (sck_rise)
               begin
                  r_next.opcode = opc_shift;
                  r_next.bits   = r_reg.bits + 3'h1;
                  if (r_reg.bits == 3'h7)
                  begin
                     r_next.bytes = 2'h1;
                     r_next.st    = fsr_pkg::fsr_st_tail;
                     if (opc_shift == `FSR_OP_RD_STAT1)
                        r_next.st = fsr_pkg::fsr_st_rd1;
                     else if (opc_shift == `FSR_OP_RD_STAT2)
                        r_next.st = fsr_pkg::fsr_st_rd2;
                     else if (opc_shift == `FSR_OP_ASI)
                     begin
                        // Drive busy now; a dummy bit changes nothing
                        r_next.st    = fsr_pkg::fsr_st_asi; // R20
                        r_next.so    = busy; // R21
                        r_next.so_oe = 1'b1;
                     end
                     else if (opc_shift == `FSR_OP_WRSR2 && r_reg.write_enable_latch)
                        r_next.st = fsr_pkg::fsr_st_wr2; // R06
                     else if (is_write_op(opc_shift) && r_reg.write_enable_latch)
                     begin
                        // Hand the command to the array engine
                        r_next.grant    = 1'b1; // R06
                        r_next.grant_op = opc_shift;
                     end
                  end
               end
            end
            fsr_pkg::fsr_st_rd1, fsr_pkg::fsr_st_rd2:
            begin
               // Fresh byte each eight bits so polling sees busy fall
               if (sck_fall)
               begin
                  r_next.so_oe = 1'b1;
                  if (r_reg.bits == 3'h0)
                  begin
                     r_next.so    = stat_sel[7]; // R13
                     r_next.shreg = {stat_sel[6:0], 1'b0};
                  end
                  else
                  begin
                     r_next.so    = r_reg.shreg[7];
                     r_next.shreg = {r_reg.shreg[6:0], 1'b0};
                  end
               end
               if (sck_rise)
               begin
                  r_next.bits = r_reg.bits + 3'h1;
               end
            end
            fsr_pkg::fsr_st_asi:
            begin
               // Follows busy down only; once low it stays low
               r_next.so    = r_reg.so & busy; // R21 R22
               r_next.so_oe = 1'b1;
            end
            fsr_pkg::fsr_st_wr2, fsr_pkg::fsr_st_tail:
            begin
               // Count data bits; only the first data byte is kept
               if (sck_rise)
               begin
                  r_next.bits = r_reg.bits + 3'h1;
                  if (r_reg.bytes == 2'h1)
                     r_next.data = {r_reg.data[6:0], si};
                  if (r_reg.bits == 3'h7 && r_reg.bytes != 2'h3)
                     r_next.bytes = r_reg.bytes + 2'h1;
               end
            end
            default:
            begin
               r_next.st = fsr_pkg::fsr_st_idle;
            end
         endcase
      end

      // Frame end: act only on a completely received opcode
      if (cs_end && r_reg.bytes != 2'h0) // R10
      begin
         if (r_reg.opcode == `FSR_OP_WREN && r_reg.bytes == 2'h1 &&
             r_reg.bits == 3'h0)
            r_next.write_enable_latch = 1'b1;
         else if (r_reg.opcode == `FSR_OP_WRDI)
            r_next.write_enable_latch = 1'b0; // R08
         else if (r_reg.opcode == `FSR_OP_WRSR2)
         begin
            // Complete byte on a byte boundary, else only the latch drops
            if (r_reg.st == fsr_pkg::fsr_st_wr2 && r_reg.bytes >= 2'h2 &&
                r_reg.bits == 3'h0)
               r_next.reset_command_enable = r_reg.data[`FSR_RESET_COMMAND_ENABLE_BIT]; // R15 R18
            r_next.write_enable_latch = 1'b0; // R08 R11
         end
         else if (is_write_op(r_reg.opcode))
            r_next.write_enable_latch = 1'b0; // R11
         else if (r_reg.opcode == `FSR_OP_RESET && r_reg.bytes == 2'h1 &&
                  r_reg.bits == 3'h0 && r_reg.reset_command_enable)
         begin
            // Device reset; reset-enable itself is kept
            r_next.srst = 1'b1; // R14 R16
            r_next.write_enable_latch  = 1'b0; // R07
         end
      end
   end

   // State register
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         r_reg          <= '0;
         r_reg.st       <= fsr_pkg::fsr_st_idle;
         r_reg.sck_q    <= 1'b0;
         r_reg.cs_q     <= 1'b1;
         r_reg.write_enable_latch      <= `FSR_WEL_RST;  // R07
         r_reg.program_erase_error      <= `FSR_EPE_RST;
         r_reg.reset_command_enable     <= `FSR_RESET_COMMAND_ENABLE_RST; // R15
      end
      else
      begin
         r_reg <= r_next;
      end
   end

   assign so          = r_reg.so;
   assign so_oe       = r_reg.so_oe;
   assign exec_grant  = r_reg.grant;
   assign exec_opcode = r_reg.grant_op;
   assign soft_reset  = r_reg.srst;

   // Checks
   default clocking cb @(posedge clock); endclocking
   default disable iff (!nrst);

   property p_grant_wel;
      exec_grant |-> $past(r_reg.write_enable_latch);
   endproperty
   a_grant_wel: assert property (p_grant_wel) // R06
      else $error("grant issued with latch clear");

   property p_epe_fail;
      op_done && op_fail |=> r_reg.program_erase_error;
   endproperty
   a_epe_fail: assert property (p_epe_fail) // R01
      else $error("error flag not set after failure");

   property p_epe_pass;
      op_done && !op_fail |=> !r_reg.program_erase_error;
   endproperty
   a_epe_pass: assert property (p_epe_pass) // R03
      else $error("error flag not cleared after success");

   property p_epe_abort;
      op_abort && !op_done |=> r_reg.program_erase_error == $past(r_reg.program_erase_error);
   endproperty
   a_epe_abort: assert property (p_epe_abort) // R02
      else $error("abort changed error flag");

   property p_wel_event;
      wel_event && !cs_end |=> !r_reg.write_enable_latch;
   endproperty
   a_wel_event: assert property (p_wel_event) // R08
      else $error("latch not cleared by engine event");

   property p_wel_partial;
      cs_end && r_reg.bytes == 2'h0 && !wel_event |=> r_reg.write_enable_latch == $past(r_reg.write_enable_latch);
   endproperty
   a_wel_partial: assert property (p_wel_partial) // R10
      else $error("partial opcode changed latch");

   property p_asi_fall;
      r_reg.st == fsr_pkg::fsr_st_asi && so_oe && !so |=> !so;
   endproperty
   a_asi_fall: assert property (p_asi_fall) // R22
      else $error("live busy output rose");

   property p_asi_drive;
      r_reg.st == fsr_pkg::fsr_st_asi && !cs_n ##1 !cs_n |->
         so_oe && (so == ($past(so) & $past(busy)));
   endproperty
   a_asi_drive: assert property (p_asi_drive) // R21
      else $error("live busy not driven");

   property p_release;
      cs_n |=> !so_oe ##1 !so_oe;
   endproperty
   a_release: assert property (p_release) // R23
      else $error("output driven after release");

   property p_reset_gate;
      soft_reset |-> $past(r_reg.reset_command_enable) && r_reg.reset_command_enable == $past(r_reg.reset_command_enable);
   endproperty
   a_reset_gate: assert property (p_reset_gate) // R14
      else $error("reset with enable clear or enable changed");

   c_asi_done: cover property (r_reg.st == fsr_pkg::fsr_st_asi && so ##[1:200] !so);
   c_grant: cover property (exec_grant);
   c_reset_command_enable_write: cover property (!r_reg.reset_command_enable ##1 r_reg.reset_command_enable);
   c_soft_reset: cover property (soft_reset);

endmodule
`default_nettype wire

// file: tb/fsr_host.sv
// Host SPI controller model driving the status block in mode 0.
// Assumes clock is the system clock; each serial phase spans 3 clocks.
`timescale 1ns/100ps
`default_nettype none
`include "fsr_defines.svh"
module fsr_host
(
   input  wire logic clock, // System clock
   input  wire logic so,    // Serial data from device
   input  wire logic so_oe, // Device drives so
   output logic      cs_n,  // Chip select, active low
   output logic      sck,   // Serial clock, idle low
   output logic      si     // Serial data to device
);
   // Idle bus at time zero
   initial
   begin
      cs_n = 1'h1;
      sck  = 1'h0;
      si   = 1'h0;
   end
   // One serial phase; 3 clocks leaves margin over the 2 minimum
   task automatic half();
      repeat (3) @(posedge clock);
   endtask
   // Select the device
   task automatic open();
      @(posedge clock);
      cs_n <= 1'h0;
      half();
   endtask
   // Shift n bits MSB first; keeps the last 8 bits seen while driven
   task automatic shift(input logic [23:0] tx, input int n, output logic [7:0] rx);
      rx = 8'h00;
      for (int i = 0; i < n; i++)
      begin
         sck <= 1'h0;
         si  <= tx[23 - i];
         half();
         sck <= 1'h1;
         if (so_oe === 1'h1)
            rx = {rx[6:0], so};
         half();
      end
      sck <= 1'h0;
      half();
   endtask
   // Release; si flips so stale data never looks valid
   task automatic close();
      cs_n <= 1'h1;
      si   <= ~si;
      half();
   endtask
   // Read byte one repeatedly until ready, bounded
   task automatic poll(output logic [7:0] last);
      open();
      shift({`FSR_OP_RD_STAT1, 16'h0000}, 8, last);
      for (int i = 0; i < 16; i++)
      begin
         shift(24'h000000, 8, last);
         if (last[0] === 1'h0)
            break;
      end
      close();
   endtask
   // Start live busy; mode 3 hosts add one dummy bit
   task automatic live(input logic mode3, output logic [7:0] rx);
      open();
      shift({`FSR_OP_ASI, 16'h0000}, 8, rx);
      if (mode3)
         shift(24'h000000, 1, rx);
   endtask
endmodule
`default_nettype wire

// file: tb/flash_status_and_busy_report_tb.sv
// Self-checking bench for the status block with a host model.
// Assumes the design's own assertions run alongside.
`timescale 1ns/100ps
`default_nettype none
`include "fsr_defines.svh"
module flash_status_and_busy_report_tb;
   logic       clock;      // 100 MHz clock
   logic       nrst;       // Reset, active low
   logic       cs_n;       // Host chip select
   logic       sck;        // Host serial clock
   logic       si;         // Host serial data
   logic       so;         // Device serial data
   logic       so_oe;      // Device drive
   logic [5:0] lv;         // Lock, seq, pin, some, all, busy
   logic [3:0] ev;         // Done, abort, seq end, hold stop
   logic       op_fail;    // Failure with done
   logic       exec_grant; // Grant pulse
   logic [7:0] exec_opcode;// Granted opcode
   logic       soft_reset; // Soft reset pulse
   logic [7:0] b;          // Scratch byte
   int         checks;     // Comparisons made
   int         error_cnt;  // Mismatches
   int         grant_cnt;  // Grants seen
   int         srst_cnt;   // Soft resets seen
   int         cyc;        // Cycle counter for timeout
   // Levels, then expected byte one and byte two
   logic [21:0] rows [8] = '{{6'h00, 8'h00, 8'h00}, {6'h08, 8'h10, 8'h00},
      {6'h04, 8'h04, 8'h00}, {6'h02, 8'h0c, 8'h00}, {6'h06, 8'h0c, 8'h00},
      {6'h21, 8'h81, 8'h01}, {6'h10, 8'h40, 8'h00}, {6'h3f, 8'hdd, 8'h01}};
   // Write-type opcodes
   logic [7:0] wops [8] = '{8'h02, 8'h20, 8'hd8, 8'h60, 8'h36, 8'h39, 8'h01, 8'had};
   fsr_status i_fsr_status (.clock(clock), .nrst(nrst), .cs_n(cs_n), .sck(sck),
      .si(si), .busy(lv[0]), .op_done(ev[0]), .op_fail(op_fail), .op_abort(ev[1]),
      .seq_end(ev[2]), .hold_stop(ev[3]), .protect_pin_level(lv[3]),
      .sectors_some(lv[2]), .sectors_all(lv[1]), .protection_regs_lock(lv[5]),
      .sequential_program_flag(lv[4]), .so(so), .so_oe(so_oe),
      .exec_grant(exec_grant), .exec_opcode(exec_opcode), .soft_reset(soft_reset));
   fsr_host i_fsr_host (.clock(clock), .so(so), .so_oe(so_oe), .cs_n(cs_n),
      .sck(sck), .si(si));
   // Clock
   initial clock = 1'h0;
   always #5 clock = ~clock;
   // Count pulses; a hang is cut short here
   always @(posedge clock)
   begin
      cyc <= cyc + 1;
      if (exec_grant === 1'h1)
         grant_cnt <= grant_cnt + 1;
      if (soft_reset === 1'h1)
         srst_cnt <= srst_cnt + 1;
      if (cyc == 40000)
      begin
         error_cnt++;
         complete_run();
      end
   end
   // Byte compare
   task automatic chk8(string nm, logic [7:0] e, logic [7:0] g);
      checks++;
      if (g !== e)
      begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   // Bit compare
   task automatic chk1(string nm, logic e, logic g);
      checks++;
      if (g !== e)
      begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   // One whole frame
   task automatic cmd(logic [23:0] tx, int n);
      i_fsr_host.open();
      i_fsr_host.shift(tx, n, b);
      i_fsr_host.close();
   endtask
   // Status read and compare
   task automatic rdchk(string nm, logic [7:0] op, logic [7:0] e);
      cmd({op, 16'h0000}, 16);
      chk8(nm, e, b);
   endtask
   // Engine pulse of one cycle
   task automatic pulse(int k);
      @(posedge clock);
      ev <= 4'h1 << k;
      @(posedge clock);
      ev <= 4'h0;
   endtask
   // Verdict
   task automatic complete_run();
      $display("checks %0d error_cnt %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // Main sequence
   initial
   begin
      {nrst, lv, ev, op_fail, checks, error_cnt, grant_cnt, srst_cnt, cyc} = '0;
      repeat (2) @(posedge clock);
      nrst <= 1'h1;
      repeat (2) @(posedge clock);
      chk1("so_oe", 1'h0, so_oe);
      chk8("exec_opcode", 8'h00, exec_opcode);
      rdchk("byte2", `FSR_OP_RD_STAT2, 8'h00);
      // Table of level combinations
      for (int i = 0; i < 8; i++)
      begin
         lv <= rows[i][21:16];
         rdchk("byte1", `FSR_OP_RD_STAT1, rows[i][15:8]);
         rdchk("byte2", `FSR_OP_RD_STAT2, rows[i][7:0]);
      end
      lv <= 6'h00;
      // Refusals with latch clear
      cmd({8'h02, 16'h0000}, 8);
      cmd({8'h31, 8'hff, 8'h00}, 16);
      chk8("grants", 8'h00, grant_cnt[7:0]);
      rdchk("byte2", `FSR_OP_RD_STAT2, 8'h00);
      // Short and unknown opcodes keep the latch
      cmd({`FSR_OP_WREN, 16'h0000}, 8);
      cmd({8'h02, 16'h0000}, 5);
      rdchk("byte1", `FSR_OP_RD_STAT1, 8'h02);
      cmd({8'hab, 16'h0000}, 8);
      rdchk("byte1", `FSR_OP_RD_STAT1, 8'h02);
      // Each write-type opcode granted, then latch cleared
      for (int i = 0; i < 8; i++)
      begin
         cmd({`FSR_OP_WREN, 16'h0000}, 8);
         cmd({wops[i], 16'h0000}, 8);
         chk8("grants", 8'(i + 1), grant_cnt[7:0]);
         chk8("exec_opcode", wops[i], exec_opcode);
         rdchk("byte1", `FSR_OP_RD_STAT1, 8'h00);
      end
      cmd({`FSR_OP_WREN, 16'h0000}, 8);
      cmd({`FSR_OP_WRDI, 16'h0000}, 8);
      rdchk("byte1", `FSR_OP_RD_STAT1, 8'h00);
      // Engine events: fail, then abort, seq end, hold keep the error
      op_fail <= 1'h1;
      for (int k = 0; k < 4; k++)
      begin
         cmd({`FSR_OP_WREN, 16'h0000}, 8);
         pulse(k);
         rdchk("byte1", `FSR_OP_RD_STAT1, 8'h20);
      end
      op_fail <= 1'h0;
      pulse(0);
      rdchk("byte1", `FSR_OP_RD_STAT1, 8'h00);
      // Abort with a clear error flag and a stray fail level sets nothing
      op_fail <= 1'h1;
      pulse(1);
      op_fail <= 1'h0;
      rdchk("byte1", `FSR_OP_RD_STAT1, 8'h00);
      // Reset enable bit and reset command
      cmd({`FSR_OP_RESET, 16'h0000}, 8);
      chk8("soft resets", 8'h00, srst_cnt[7:0]);
      cmd({`FSR_OP_WREN, 16'h0000}, 8);
      cmd({`FSR_OP_WRSR2, 8'hff, 8'h00}, 16);
      rdchk("byte2", `FSR_OP_RD_STAT2, 8'h10);
      cmd({`FSR_OP_RESET, 16'h0000}, 8);
      chk8("soft resets", 8'h01, srst_cnt[7:0]);
      rdchk("byte2", `FSR_OP_RD_STAT2, 8'h10);
      cmd({`FSR_OP_WREN, 16'h0000}, 8);
      cmd({`FSR_OP_WRSR2, 8'hef, 8'h00}, 12);
      rdchk("byte2", `FSR_OP_RD_STAT2, 8'h10);
      rdchk("byte1", `FSR_OP_RD_STAT1, 8'h00);
      cmd({`FSR_OP_WREN, 16'h0000}, 8);
      cmd({`FSR_OP_WRSR2, 8'hef, 8'h00}, 16);
      rdchk("byte2", `FSR_OP_RD_STAT2, 8'h00);
      // Live busy: falls with busy, never rises, ends with select
      lv <= 6'h01;
      i_fsr_host.live(1'h1, b);
      chk1("so_oe", 1'h1, so_oe);
      chk1("so", 1'h1, so);
      lv <= 6'h00;
      repeat (3) @(posedge clock);
      chk1("so", 1'h0, so);
      lv <= 6'h01;
      repeat (3) @(posedge clock);
      chk1("so", 1'h0, so);
      i_fsr_host.close();
      chk1("so_oe", 1'h0, so_oe);
      // Read cut short in mid-byte
      i_fsr_host.open();
      i_fsr_host.shift({`FSR_OP_RD_STAT1, 16'h0000}, 12, b);
      i_fsr_host.close();
      chk1("so_oe", 1'h0, so_oe);
      // Polling until ready
      fork
         i_fsr_host.poll(b);
         begin
            repeat (200) @(posedge clock);
            lv <= 6'h00;
         end
      join
      chk1("ready", 1'h0, b[0]);
      // Reset in mid-run with the latch set and an opcode granted earlier
      cmd({`FSR_OP_WREN, 16'h0000}, 8);
      nrst <= 1'h0;
      repeat (2) @(posedge clock);
      nrst <= 1'h1;
      repeat (2) @(posedge clock);
      chk1("so_oe", 1'h0, so_oe);
      chk8("exec_opcode", 8'h00, exec_opcode);
      rdchk("byte1", `FSR_OP_RD_STAT1, 8'h00);
      rdchk("byte2", `FSR_OP_RD_STAT2, 8'h00);
      complete_run();
   end
endmodule
`default_nettype wire
